/* verilog/bts_unit.sv */
// bit-test skip decode and execute
`timescale 1ns/10ps
`default_nettype none
module bts_unit
  import bts_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // instruction stream
  input  wire logic        INSTR_VALID,
  input  wire logic [15:0] INSTR,
  input  wire logic        NEXT_IS_TWO_WORD,
  // addressing context
  input  wire logic [3:0]  BANK_SELECTOR_REGISTER,
  input  wire logic        EXT_SET_EN,
  input  wire logic [11:0] FSR2_BASE,
  // data memory read
  output logic [11:0]      DATA_ADDR,
  output logic             DATA_RD,
  input  wire logic [7:0]  DATA_RDATA,
  // pipeline control
  output logic             IS_BIT_TEST,
  output logic             SKIP,
  output logic             FLUSH,
  output logic             BUSY,
  output logic             DONE
);
  bts_regs_t r_reg;
  bts_regs_t r_next;

  function automatic logic [11:0] form_addr(
    input logic [7:0] f, input logic a, input logic [3:0] bank,
    input logic ext, input logic [11:0] base);
    if (a)
      form_addr = {bank, f};
    else if (ext && f <= IDX_LIMIT)
      form_addr = base + {4'h0, f};
    else if (f >= ACCESS_SPLIT)
      form_addr = {ACCESS_HIGH_BANK, f};
    else
      form_addr = {ACCESS_LOW_BANK, f};
  endfunction

  logic [3:0]  opc;
  logic        hit_clear;
  logic        hit_set;
  logic        bit_val;
  logic        take_skip;
  logic [11:0] cur_addr;

  always_comb begin
    opc       = INSTR[OPC_MSB:OPC_LSB];
    hit_clear = INSTR_VALID && opc == OPC_SKIP_CLEAR;
    hit_set   = INSTR_VALID && opc == OPC_SKIP_SET;
    cur_addr  = form_addr(INSTR[7:0], INSTR[BANK_MODE_POS],
                          BANK_SELECTOR_REGISTER, EXT_SET_EN, FSR2_BASE);
    bit_val   = DATA_RDATA[INSTR[BIT_MSB:BIT_LSB]];
    take_skip = (hit_clear && !bit_val) || (hit_set && bit_val);
  end

  always_comb begin
    r_next       = r_reg;
    r_next.flush = 1'b0;
    r_next.done  = 1'b0;
    case (r_reg.state)
      BTS_EXEC: begin
        r_next.busy = 1'b0;
        if (hit_clear || hit_set) begin
          r_next.addr = cur_addr;
          if (take_skip) begin
            r_next.flush         = 1'b1;
            r_next.busy          = 1'b1;
            r_next.skip_two_word = NEXT_IS_TWO_WORD;
            r_next.state         = BTS_NOP1;
          end else begin
            r_next.done = 1'b1;
          end
        end
      end
      BTS_NOP1: begin
        if (r_reg.skip_two_word) begin
          r_next.state = BTS_NOP2;
        end else begin
          r_next.busy  = 1'b0;
          r_next.done  = 1'b1;
          r_next.state = BTS_EXEC;
        end
      end
      BTS_NOP2: begin
        r_next.busy          = 1'b0;
        r_next.done          = 1'b1;
        r_next.skip_two_word = 1'b0;
        r_next.state         = BTS_EXEC;
      end
      default: r_next.state = BTS_EXEC;
    endcase
    if (RST) begin
      r_next.state         = BTS_EXEC;
      r_next.skip_two_word = 1'b0;
      r_next.addr          = ADDR_RESET;
      r_next.busy          = 1'b0;
      r_next.flush         = 1'b0;
      r_next.done          = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    r_reg <= r_next;
  end

  // read only, never writes memory or flags
  assign DATA_ADDR   = cur_addr;
  assign DATA_RD     = (hit_clear || hit_set) && r_reg.state == BTS_EXEC;
  assign IS_BIT_TEST = hit_clear || hit_set;
  assign SKIP        = take_skip && r_reg.state == BTS_EXEC;
  assign FLUSH       = r_reg.flush;
  assign BUSY        = r_reg.busy;
  assign DONE        = r_reg.done;
endmodule
`default_nettype wire

/* verilog/bts_pkg.sv */
// constants and types for the bit-test skip execution unit
// Operation
// - opcode top nibble 1011 tests bit, skips next instruction on zero.
// - opcode 1010 bbba ffff ffff skips next instruction when tested bit is one.
// - on skip, discard the fetched next instruction and run a no-op instead.
// - one cycle without skip, two on skip, three over two-word instruction.
// - bank-mode bit zero resolves the address inside the fixed access bank.
// - bank-mode bit one takes the bank from the bank selector register.
// - bank-mode zero, extended set, address up to 95: indexed literal offset.
package bts_pkg;
  localparam logic [3:0]  OPC_SKIP_CLEAR   = 4'hB;
  localparam logic [3:0]  OPC_SKIP_SET     = 4'hA;
  localparam int          OPC_MSB          = 15;
  localparam int          OPC_LSB          = 12;
  localparam int          BIT_MSB          = 11;
  localparam int          BIT_LSB          = 9;
  localparam int          BANK_MODE_POS    = 8;
  localparam logic [7:0]  IDX_LIMIT        = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
  localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0]  ACCESS_LOW_BANK  = 4'h0;
  localparam logic [11:0] ADDR_RESET       = 12'h000;

  typedef enum logic [1:0] {
    BTS_EXEC,
    BTS_NOP1,
    BTS_NOP2
  } bts_state_t;

  typedef struct packed {
    bts_state_t  state;
    logic        skip_two_word;
    logic [11:0] addr;
    logic        busy;
    logic        flush;
    logic        done;
  } bts_regs_t;
endpackage

/* sim/bts_chk.sv */
// assertions on the bit-test skip unit ports
`timescale 1ns/10ps
`default_nettype none
module bts_chk (
  // watched ports
  input wire logic        CLOCK, RST, INSTR_VALID, NEXT_IS_TWO_WORD,
  input wire logic        EXT_SET_EN, DATA_RD, SKIP, FLUSH, BUSY, DONE,
  input wire logic [15:0] INSTR,
  input wire logic [3:0]  BANK_SELECTOR_REGISTER,
  input wire logic [11:0] FSR2_BASE, DATA_ADDR,
  input wire logic [7:0]  DATA_RDATA
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_clear_skip: assert property (DATA_RD && INSTR[15:12] == 4'hB |->
    SKIP == !DATA_RDATA[INSTR[11:9]]) else $error("skip on clear wrong");
  a_set_skip: assert property (DATA_RD && INSTR[15:12] == 4'hA |->
    SKIP == DATA_RDATA[INSTR[11:9]]) else $error("skip on set wrong");
  a_skip_flush: assert property (SKIP |=> FLUSH && BUSY)
    else $error("skip without flush");
  a_one_cycle: assert property (DATA_RD && !SKIP |=> DONE && !BUSY)
    else $error("no-skip length wrong");
  a_two_word: assert property (SKIP && NEXT_IS_TWO_WORD |=>
    BUSY ##1 BUSY ##1 DONE) else $error("two-word skip length wrong");
  a_bank_sel: assert property (DATA_RD && INSTR[8] |->
    DATA_ADDR == {BANK_SELECTOR_REGISTER, INSTR[7:0]}) else $error("bank");
  a_access_bank: assert property (DATA_RD && !INSTR[8] &&
    (!EXT_SET_EN || INSTR[7:0] > 8'h5F) |-> DATA_ADDR ==
    {(INSTR[7:0] > 8'h5F) ? 4'hF : 4'h0, INSTR[7:0]}) else $error("access");
  a_indexed: assert property (DATA_RD && !INSTR[8] && EXT_SET_EN &&
    INSTR[7:0] < 8'h60 |-> DATA_ADDR == FSR2_BASE + INSTR[7:0])
    else $error("indexed address wrong");
endmodule
bind bts_unit bts_chk u_chk (.CLOCK, .RST, .INSTR_VALID, .NEXT_IS_TWO_WORD,
  .EXT_SET_EN, .DATA_RD, .SKIP, .FLUSH, .BUSY, .DONE, .INSTR,
  .BANK_SELECTOR_REGISTER, .FSR2_BASE, .DATA_ADDR, .DATA_RDATA);
`default_nettype wire

/* sim/tb.sv */
// testbench for the bit-test skip unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        CLOCK = 0, RST = 1, vld = 0, tw = 0, ext = 0, sk;
  logic [15:0] ins = 0;
  logic [7:0]  rd = 0;
  logic [3:0]  bank_selector_register = 4'h5;
  logic [11:0] base = 12'hFF0;
  int          n, errors, checks_done;
  bts_unit DUT (.CLOCK, .RST, .INSTR_VALID(vld), .INSTR(ins),
    .NEXT_IS_TWO_WORD(tw), .BANK_SELECTOR_REGISTER(bank_selector_register), .EXT_SET_EN(ext),
    .FSR2_BASE(base), .DATA_ADDR(), .DATA_RD(), .DATA_RDATA(rd),
    .IS_BIT_TEST(), .SKIP(), .FLUSH(), .BUSY(), .DONE());
  initial forever #2.5 CLOCK = ~CLOCK;
  task automatic finish_test;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [15:0] i, input logic [7:0] d,
                       input logic two, input logic [11:0] ea);
    @(negedge CLOCK); vld = 1; ins = i; rd = d; tw = two;
    #1 sk = DUT.SKIP;
    chk(DUT.DATA_ADDR, ea);
    chk(DUT.IS_BIT_TEST, 1);
    chk(DUT.DATA_RD, 1);
    @(negedge CLOCK); vld = 0; n = 1;
    chk(DUT.FLUSH, sk);
    chk(DUT.BUSY, sk);
    while (DUT.DONE !== 1'b1 && n < 9) begin @(negedge CLOCK); n++; end
    if (n == 9) begin errors++; finish_test; end
  endtask
  task automatic t_bits;
    for (int b = 0; b < 8; b++) for (int s = 0; s < 2; s++)
      for (int v = 0; v < 2; v++) begin
        issue({s ? 4'hA : 4'hB, 3'(b), 1'b1, 8'h10},
          v ? 8'h01 << b : ~(8'h01 << b), 0, 12'h510);
        chk(sk, s == v);
        chk(12'(n), (s == v) ? 2 : 1);
      end
  endtask
  task automatic t_two;
    issue(16'hB310, 8'h00, 1, 12'h510);
    chk(12'(n), 3);
    issue(16'hA310, 8'h00, 1, 12'h510);
    chk(12'(n), 1);
  endtask
  task automatic t_addr;
    issue(16'hA080, 8'h00, 0, 12'hF80);
    issue(16'hA05F, 8'h00, 0, 12'h05F);
    ext = 1;
    issue(16'hA05F, 8'h00, 0, 12'h04F);
    issue(16'hA060, 8'h00, 0, 12'hF60);
    issue(16'hA160, 8'h00, 0, 12'h560);
  endtask
  task automatic t_misc;
    @(negedge CLOCK); vld = 1; ins = 16'h8310; rd = 8'h00; tw = 0;
    #1 chk(DUT.IS_BIT_TEST, 0);
    chk(DUT.DATA_RD, 0);
    chk(DUT.SKIP, 0);
    @(negedge CLOCK); chk(DUT.DONE, 0);
    ins = 16'hB310;
    #1 chk(DUT.SKIP, 1);
    @(negedge CLOCK);
    #1 chk(DUT.DATA_RD, 0);
    chk(DUT.SKIP, 0);
    chk(DUT.BUSY, 1);
    @(negedge CLOCK); chk(DUT.DONE, 1);
    vld = 0;
  endtask
  initial begin
    repeat (10) @(negedge CLOCK);
    RST = 0;
    t_bits;
    t_two;
    t_addr;
    t_misc;
    finish_test;
  end
endmodule
`default_nettype wire
